// >>> src/fccs_ctrl.sv
`timescale 1ns/10ps
`include "fccs_consts.svh"

module fccs_ctrl
    import fccs_pkg::*;
(
    // clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_srst,
    // user command port
    input  wire logic                    i_cmd_valid,
    input  wire fccs_op_e                i_cmd_op,
    input  wire logic [`FCCS_ADDR_W-1:0] i_cmd_addr,
    input  wire logic [`FCCS_DATA_W-1:0] i_cmd_data,
    input  wire logic [1:0]              i_cmd_lanes,
    output logic                         o_cmd_ready,
    // user response port
    output logic                         o_rsp_valid,
    output logic                         o_rsp_err,
    output logic [`FCCS_DATA_W-1:0]      o_rsp_data,
    output logic                         o_window_open,
    output logic                         o_card_busy,
    // card pins
    output logic                         o_reset_n,
    output logic                         o_low_lane_select_n,
    output logic                         o_high_lane_select_n,
    output logic                         o_oe_n,
    output logic                         o_we_n,
    output logic [`FCCS_ADDR_W-1:0]      o_addr,
    output logic [`FCCS_DATA_W-1:0]      o_data,
    output logic [1:0]                   o_data_oe,
    input  wire logic [`FCCS_DATA_W-1:0] i_data,
    input  wire logic                    i_busy_n
);
    localparam logic [`FCCS_CNT_W-1:0] WIN_CYC  = `FCCS_CNT_W'(`FCCS_WIN_CYC);
    localparam logic [`FCCS_CNT_W-1:0] RST_CYC  = `FCCS_CNT_W'(`FCCS_RST_CYC);
    localparam logic [`FCCS_CNT_W-1:0] RDY_CYC  = `FCCS_CNT_W'(`FCCS_RDY_CYC);
    localparam logic [`FCCS_CNT_W-1:0] WAKE_CYC = `FCCS_CNT_W'(`FCCS_WAKE_CYC);
    localparam logic [`FCCS_CNT_W-1:0] BUSY_DLY = `FCCS_CNT_W'(`FCCS_BUSY_DLY);

    fccs_cyc_if cyc ();

    fccs_state_e                 st_q;
    fccs_op_e                    op_q;
    logic [2:0]                  step_q;
    logic [2:0]                  last_q;
    logic [`FCCS_ADDR_W-1:0]     addr_q;
    logic [`FCCS_DATA_W-1:0]     data_q;
    logic [1:0]                  lanes_q;
    logic                        req_q;
    logic [`FCCS_CNT_W-1:0]      cnt_q;
    logic [`FCCS_CNT_W-1:0]      win_q;

    // number of write cycles per command, minus one
    function automatic logic [2:0] seq_last(input fccs_op_e op);
        unique case (op)
            FCCS_OP_IDENT:   seq_last = 3'h2;
            FCCS_OP_PROGRAM: seq_last = 3'h3;
            FCCS_OP_CHIP_ER: seq_last = 3'h5;
            FCCS_OP_SECT_ER: seq_last = 3'h5;
            default:         seq_last = 3'h0;
        endcase
    endfunction : seq_last

    // command byte for a given step of a sequence
    function automatic logic [7:0] seq_byte(input fccs_op_e op, input logic [2:0] step);
        logic [7:0] b;
        b = `FCCS_D_RESET;
        if (op == FCCS_OP_SUSPEND) begin
            b = `FCCS_D_SUSPEND;
        end else if (op == FCCS_OP_RESUME) begin
            b = `FCCS_D_RESUME;
        end else if (op == FCCS_OP_ADD_SECT) begin
            b = `FCCS_D_SECTOR;
        end else if (op != FCCS_OP_RESET) begin
            unique case (step)
                3'h0:    b = `FCCS_D_UNLOCK1;
                3'h1:    b = `FCCS_D_UNLOCK2;
                3'h2: begin
                    if (op == FCCS_OP_IDENT) begin
                        b = `FCCS_D_IDENT;
                    end else if (op == FCCS_OP_PROGRAM) begin
                        b = `FCCS_D_PROGRAM;
                    end else begin
                        b = `FCCS_D_ERASE;
                    end
                end
                3'h3:    b = `FCCS_D_UNLOCK1;
                3'h4:    b = `FCCS_D_UNLOCK2;
                default: b = (op == FCCS_OP_CHIP_ER) ? `FCCS_D_CHIP : `FCCS_D_SECTOR;
            endcase
        end
        seq_byte = b;
    endfunction : seq_byte

    // program data goes out as given; every other byte on both lanes
    assign cyc.wr    = (st_q == FCCS_ST_WRITE);
    assign cyc.req   = req_q;
    assign cyc.addr  = addr_q;
    assign cyc.lanes = lanes_q;
    assign cyc.wdata = (op_q == FCCS_OP_PROGRAM && step_q == 3'h3) ? data_q
                     : {2{seq_byte(op_q, step_q)}};

    fccs_bus_cycle u_bus_cycle (
        .i_clk_sys            (i_clk_sys),
        .i_srst               (i_srst),
        .cyc                  (cyc.bus),
        .o_low_lane_select_n  (o_low_lane_select_n),
        .o_high_lane_select_n (o_high_lane_select_n),
        .o_oe_n               (o_oe_n),
        .o_we_n               (o_we_n),
        .o_addr               (o_addr),
        .o_data               (o_data),
        .o_data_oe            (o_data_oe),
        .i_data               (i_data)
    );

    // accumulation window timer, restarted by each sector confirm
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            win_q <= '0;
        end else if (st_q == FCCS_ST_WRITE && cyc.done && step_q == last_q) begin
            if (op_q == FCCS_OP_SECT_ER || op_q == FCCS_OP_ADD_SECT) begin
                win_q <= WIN_CYC;
            end else begin
                win_q <= '0;
            end
        end else if (st_q == FCCS_ST_RST) begin
            win_q <= '0;
        end else if (win_q != '0) begin
            win_q <= win_q - `FCCS_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_window_open <= 1'b0;
            o_card_busy   <= 1'b0;
        end else begin
            o_window_open <= (win_q > `FCCS_CNT_W'(1));
            o_card_busy   <= ~i_busy_n;
        end
    end

    // main command sequencer
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_q        <= FCCS_ST_IDLE;
            op_q        <= FCCS_OP_READ;
            step_q      <= 3'h0;
            last_q      <= 3'h0;
            addr_q      <= '0;
            data_q      <= '0;
            lanes_q     <= 2'h0;
            req_q       <= 1'b0;
            cnt_q       <= '0;
            o_cmd_ready <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_err   <= 1'b0;
            o_rsp_data  <= '0;
            o_reset_n   <= 1'b1;
        end else begin
            req_q       <= 1'b0;
            o_rsp_valid <= 1'b0;
            unique case (st_q)
                FCCS_ST_IDLE: begin
                    o_cmd_ready <= 1'b1;
                    if (i_cmd_valid && o_cmd_ready) begin
                        o_cmd_ready <= 1'b0;
                        op_q        <= i_cmd_op;
                        addr_q      <= i_cmd_addr;
                        data_q      <= i_cmd_data;
                        lanes_q     <= i_cmd_lanes;
                        step_q      <= 3'h0;
                        last_q      <= seq_last(i_cmd_op);
                        o_rsp_err   <= 1'b0;
                        if (i_cmd_op == FCCS_OP_HW_RESET) begin
                            o_reset_n <= 1'b0;
                            cnt_q     <= RST_CYC;
                            st_q      <= FCCS_ST_RST;
                        end else if (i_cmd_op == FCCS_OP_WAIT) begin
                            cnt_q <= '0;
                            st_q  <= FCCS_ST_WAIT;
                        end else if (i_cmd_op == FCCS_OP_READ) begin
                            req_q <= 1'b1;
                            st_q  <= FCCS_ST_READ;
                        end else if (i_cmd_op == FCCS_OP_ADD_SECT && !o_window_open) begin
                            // a late confirm would not be taken by the card
                            o_rsp_err <= 1'b1;
                            st_q      <= FCCS_ST_RESP;
                        end else begin
                            req_q <= 1'b1;
                            st_q  <= FCCS_ST_WRITE;
                        end
                    end
                end
                FCCS_ST_WRITE: begin
                    if (cyc.done) begin
                        if (step_q == last_q) begin
                            if (op_q == FCCS_OP_PROGRAM || op_q == FCCS_OP_CHIP_ER
                                || op_q == FCCS_OP_RESUME) begin
                                cnt_q <= BUSY_DLY;
                                st_q  <= FCCS_ST_WAIT;
                            end else begin
                                st_q <= FCCS_ST_RESP;
                            end
                        end else begin
                            step_q <= step_q + 3'h1;
                            req_q  <= 1'b1;
                        end
                    end
                end
                FCCS_ST_READ: begin
                    if (cyc.done) begin
                        o_rsp_data <= cyc.rdata;
                        st_q       <= FCCS_ST_RESP;
                    end
                end
                FCCS_ST_WAIT: begin
                    // no new command reaches the card until busy drops
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - `FCCS_CNT_W'(1);
                    end else if (i_busy_n) begin
                        st_q <= FCCS_ST_RESP;
                    end
                end
                FCCS_ST_RST: begin
                    if (cnt_q == `FCCS_CNT_W'(1)) begin
                        o_reset_n <= 1'b1;
                        cnt_q     <= (RDY_CYC > RST_CYC + WAKE_CYC)
                                   ? RDY_CYC - RST_CYC : WAKE_CYC;
                        st_q      <= FCCS_ST_RECOV;
                    end else begin
                        cnt_q <= cnt_q - `FCCS_CNT_W'(1);
                    end
                end
                FCCS_ST_RECOV: begin
                    if (cnt_q == `FCCS_CNT_W'(1)) begin
                        st_q <= FCCS_ST_RESP;
                    end else begin
                        cnt_q <= cnt_q - `FCCS_CNT_W'(1);
                    end
                end
                FCCS_ST_RESP: begin
                    o_rsp_valid <= 1'b1;
                    st_q        <= FCCS_ST_IDLE;
                end
            endcase
        end
    end

endmodule : fccs_ctrl

// >>> inc/fccs_consts.svh
// Notes on behaviour
// - program is four write cycles; fourth starts it
// - extra sector confirms each within fifty microseconds
// - status reads must hit a sector being erased
// - identifier mode left only by read/reset command; the card model also leaves it on hardware reset
// - hold reset low at least five hundred nanoseconds
`ifndef FCCS_CONSTS_SVH
`define FCCS_CONSTS_SVH

`define FCCS_CLK_MHZ     40
`define FCCS_CLK_NS      25
`define FCCS_ADDR_W      21
`define FCCS_DATA_W      16

// strobe and access widths on the card pins
`define FCCS_T_WE_NS     50
`define FCCS_WE_CYC      ((`FCCS_T_WE_NS + `FCCS_CLK_NS - 1) / `FCCS_CLK_NS)
`define FCCS_T_RD_NS     150
`define FCCS_RD_CYC      ((`FCCS_T_RD_NS + `FCCS_CLK_NS - 1) / `FCCS_CLK_NS)

// sector accumulation window, longest time so rounded down
`define FCCS_T_WIN_US    50
`define FCCS_WIN_CYC     (`FCCS_T_WIN_US * `FCCS_CLK_MHZ)

// hardware reset pulse, least time so rounded up
`define FCCS_T_RST_NS    500
`define FCCS_RST_CYC     ((`FCCS_T_RST_NS + `FCCS_CLK_NS - 1) / `FCCS_CLK_NS)
// ready in read mode after reset assertion
`define FCCS_T_RDY_US    20
`define FCCS_RDY_CYC     (`FCCS_T_RDY_US * `FCCS_CLK_MHZ)
// wake time after reset release
`define FCCS_T_WAKE_NS   500
`define FCCS_WAKE_CYC    ((`FCCS_T_WAKE_NS + `FCCS_CLK_NS - 1) / `FCCS_CLK_NS)

// cycles before busy is trusted after the starting write
`define FCCS_BUSY_DLY    4
`define FCCS_CNT_W       16

// command bytes, replicated on both lanes
`define FCCS_D_UNLOCK1   8'hAA
`define FCCS_D_UNLOCK2   8'h55
`define FCCS_D_RESET     8'hF0
`define FCCS_D_IDENT     8'h90
`define FCCS_D_PROGRAM   8'hA0
`define FCCS_D_ERASE     8'h80
`define FCCS_D_CHIP      8'h10
`define FCCS_D_SECTOR    8'h30
`define FCCS_D_SUSPEND   8'hB0
`define FCCS_D_RESUME    8'h30

`endif

// >>> inc/fccs_pkg.sv
package fccs_pkg;

    typedef enum logic [3:0] {
        FCCS_OP_READ     = 4'h0,
        FCCS_OP_RESET    = 4'h1,
        FCCS_OP_IDENT    = 4'h2,
        FCCS_OP_PROGRAM  = 4'h3,
        FCCS_OP_CHIP_ER  = 4'h4,
        FCCS_OP_SECT_ER  = 4'h5,
        FCCS_OP_ADD_SECT = 4'h6,
        FCCS_OP_SUSPEND  = 4'h7,
        FCCS_OP_RESUME   = 4'h8,
        FCCS_OP_WAIT     = 4'h9,
        FCCS_OP_HW_RESET = 4'hA
    } fccs_op_e;

    typedef enum logic [6:0] {
        FCCS_ST_IDLE  = 7'h01,
        FCCS_ST_WRITE = 7'h02,
        FCCS_ST_READ  = 7'h04,
        FCCS_ST_WAIT  = 7'h08,
        FCCS_ST_RST   = 7'h10,
        FCCS_ST_RECOV = 7'h20,
        FCCS_ST_RESP  = 7'h40
    } fccs_state_e;

    typedef enum logic [3:0] {
        FCCS_CY_IDLE   = 4'h1,
        FCCS_CY_SETUP  = 4'h2,
        FCCS_CY_STROBE = 4'h4,
        FCCS_CY_HOLD   = 4'h8
    } fccs_cyc_state_e;

endpackage : fccs_pkg

// >>> inc/fccs_cyc_if.sv
`timescale 1ns/10ps
`include "fccs_consts.svh"

interface fccs_cyc_if;
    logic                     req;
    logic                     wr;
    logic [1:0]               lanes;
    logic [`FCCS_ADDR_W-1:0]  addr;
    logic [`FCCS_DATA_W-1:0]  wdata;
    logic                     done;
    logic [`FCCS_DATA_W-1:0]  rdata;

    modport master (output req, wr, lanes, addr, wdata, input done, rdata);
    modport bus    (input req, wr, lanes, addr, wdata, output done, rdata);
endinterface : fccs_cyc_if

// >>> src/fccs_bus_cycle.sv
`timescale 1ns/10ps
`include "fccs_consts.svh"

module fccs_bus_cycle
    import fccs_pkg::*;
(
    // clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_srst,
    // request side
    fccs_cyc_if.bus                      cyc,
    // card pins
    output logic                         o_low_lane_select_n,
    output logic                         o_high_lane_select_n,
    output logic                         o_oe_n,
    output logic                         o_we_n,
    output logic [`FCCS_ADDR_W-1:0]      o_addr,
    output logic [`FCCS_DATA_W-1:0]      o_data,
    output logic [1:0]                   o_data_oe,
    input  wire logic [`FCCS_DATA_W-1:0] i_data
);
    localparam logic [3:0] WE_CYC = 4'(`FCCS_WE_CYC);
    localparam logic [3:0] RD_CYC = 4'(`FCCS_RD_CYC);

    fccs_cyc_state_e st_q;
    logic [3:0]      cnt_q;
    logic            wr_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_q                 <= FCCS_CY_IDLE;
            cnt_q                <= 4'h0;
            wr_q                 <= 1'b0;
            o_low_lane_select_n  <= 1'b1;
            o_high_lane_select_n <= 1'b1;
            o_oe_n               <= 1'b1;
            o_we_n               <= 1'b1;
            o_addr               <= '0;
            o_data               <= '0;
            o_data_oe            <= 2'h0;
            cyc.done             <= 1'b0;
            cyc.rdata            <= '0;
        end else begin
            cyc.done <= 1'b0;
            unique case (st_q)
                FCCS_CY_IDLE: begin
                    if (cyc.req) begin
                        // address and selects settle before any strobe edge
                        o_addr               <= cyc.addr;
                        o_data               <= cyc.wdata;
                        wr_q                 <= cyc.wr;
                        o_low_lane_select_n  <= ~cyc.lanes[0];
                        o_high_lane_select_n <= ~cyc.lanes[1];
                        o_data_oe            <= cyc.wr ? cyc.lanes : 2'h0;
                        st_q                 <= FCCS_CY_SETUP;
                    end
                end
                FCCS_CY_SETUP: begin
                    o_we_n <= ~wr_q;
                    o_oe_n <= wr_q;
                    cnt_q  <= wr_q ? WE_CYC : RD_CYC;
                    st_q   <= FCCS_CY_STROBE;
                end
                FCCS_CY_STROBE: begin
                    if (cnt_q == 4'h1) begin
                        // data held stable through the rising write edge
                        o_we_n <= 1'b1;
                        o_oe_n <= 1'b1;
                        if (!wr_q) begin
                            cyc.rdata <= i_data;
                        end
                        st_q <= FCCS_CY_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                FCCS_CY_HOLD: begin
                    o_low_lane_select_n  <= 1'b1;
                    o_high_lane_select_n <= 1'b1;
                    o_data_oe            <= 2'h0;
                    cyc.done             <= 1'b1;
                    st_q                 <= FCCS_CY_IDLE;
                end
            endcase
        end
    end

endmodule : fccs_bus_cycle

// >>> dv/fccs_ctrl_monitor.sv
`timescale 1ns/10ps
`include "fccs_consts.svh"

module fccs_ctrl_monitor
    import fccs_pkg::*;
(
    // clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_srst,
    // user side
    input  wire logic                    i_cmd_valid,
    input  wire fccs_op_e                i_cmd_op,
    input  wire logic                    o_cmd_ready,
    input  wire logic                    o_rsp_valid,
    input  wire logic                    o_rsp_err,
    input  wire logic                    o_window_open,
    input  wire logic                    o_card_busy,
    input  wire logic                    i_busy_n,
    // card side
    input  wire logic                    o_reset_n,
    input  wire logic                    o_low_lane_select_n,
    input  wire logic                    o_high_lane_select_n,
    input  wire logic                    o_oe_n,
    input  wire logic                    o_we_n,
    input  wire logic [`FCCS_ADDR_W-1:0] o_addr,
    input  wire logic [`FCCS_DATA_W-1:0] o_data,
    input  wire logic [1:0]              o_data_oe
);
    logic [4:0] rst_low_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    // length of the card reset pulse
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || o_reset_n) begin
            rst_low_q <= 5'h00;
        end else if (rst_low_q != 5'h1F) begin
            rst_low_q <= rst_low_q + 5'h01;
        end
    end

    sequence s_read_take;
        i_cmd_valid && o_cmd_ready && i_cmd_op == FCCS_OP_READ;
    endsequence
    sequence s_we_pulse;
        !o_we_n [*2] ##1 o_we_n;
    endsequence
    sequence s_refused;
        ##[1:2] (o_rsp_valid && o_rsp_err);
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0)
        i_srst |=> !o_cmd_ready && !o_rsp_valid && o_reset_n && o_we_n && o_oe_n)
        else $error("outputs active during reset");
    a_rsp_pulse: assert property (o_rsp_valid |=> !o_rsp_valid && o_cmd_ready)
        else $error("response pulse too long or ready late");
    a_read_time: assert property (s_read_take |-> ##12 o_rsp_valid)
        else $error("read answer late");
    a_we_width: assert property ($fell(o_we_n) |-> s_we_pulse)
        else $error("write strobe width wrong");
    a_addr_stable: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_data))
        else $error("address or data moved under strobe");
    a_data_hold: assert property ($rose(o_we_n) |-> $stable(o_data) && o_data_oe != 2'h0)
        else $error("data not held past strobe rise");
    a_lane_drive: assert property (!o_we_n |-> o_oe_n && o_reset_n
        && o_data_oe[0] == !o_low_lane_select_n && o_data_oe[1] == !o_high_lane_select_n)
        else $error("lane drive does not match selects");
    a_hw_rst_width: assert property ($rose(o_reset_n) |-> rst_low_q >= 5'h14)
        else $error("card reset pulse short");
    a_card_quiet: assert property (!o_reset_n |-> o_we_n && o_oe_n)
        else $error("strobe during card reset");
    a_add_refuse: assert property (i_cmd_valid && o_cmd_ready
        && i_cmd_op == FCCS_OP_ADD_SECT && !o_window_open |=> o_we_n throughout s_refused)
        else $error("late sector add not refused");
    a_busy_follow: assert property (o_card_busy == !$past(i_busy_n))
        else $error("busy flag does not follow card");
endmodule : fccs_ctrl_monitor

// >>> dv/fccs_card_model.sv
`timescale 1ns/10ps
`include "fccs_consts.svh"

module fccs_card_model #(
    parameter logic [15:0] MFR_CODE  = 16'h00C3, // arbitrary value
    parameter logic [15:0] DEV_CODE  = 16'h00D7, // arbitrary value
    parameter int          PROG_CYC  = 40,
    parameter int          ERASE_CYC = 80
) (
    // card pins from controller
    input  wire logic                    i_reset_n,
    input  wire logic                    i_lo_n,
    input  wire logic                    i_hi_n,
    input  wire logic                    i_oe_n,
    input  wire logic                    i_we_n,
    input  wire logic [`FCCS_ADDR_W-1:0] i_addr,
    input  wire logic [`FCCS_DATA_W-1:0] i_bus,
    // card outputs
    output logic [`FCCS_DATA_W-1:0]      o_q,
    output logic                         o_busy_n
);
    logic [15:0] mem [int];
    logic [20:0] a_q;
    logic [15:0] rd = 16'h0000;
    logic [7:0]  b;
    logic        ident = 1'b0;
    int          step = 0;
    int          busy_left = 0;

    function automatic logic [15:0] peek(input logic [20:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : 16'hFFFF;
    endfunction : peek

    // released lanes show the inverse pattern
    assign o_q[7:0]  = (!i_oe_n && !i_lo_n && i_reset_n) ? rd[7:0] : ~rd[7:0];
    assign o_q[15:8] = (!i_oe_n && !i_hi_n && i_reset_n) ? rd[15:8] : ~rd[15:8];
    assign o_busy_n  = (busy_left == 0);

    always #25 if (busy_left > 0) busy_left--;

    always @(negedge i_oe_n) begin
        rd = ident ? (i_addr == 21'h0 ? MFR_CODE : (i_addr == 21'h1 ? DEV_CODE : 16'h0)) : peek(i_addr);
    end

    always @(negedge i_we_n) a_q = i_addr;

    always @(negedge i_reset_n) begin
        busy_left = 0;
        step = 0;
        ident = 1'b0;
    end

    always @(posedge i_we_n) begin
        b = i_lo_n ? i_bus[15:8] : i_bus[7:0];
        if (!i_reset_n || (i_lo_n && i_hi_n) || busy_left > 0) begin
            b = 8'h00;
        end else if (step == 3) begin
            mem[int'(a_q)] = peek(a_q) & i_bus;
            busy_left = PROG_CYC;
            step = 0;
        end else if (step == 6 && b == 8'h10) begin
            mem.delete();
            busy_left = ERASE_CYC;
            step = 0;
        end else if (step == 6 && b == 8'h30) begin
            foreach (mem[k]) if (k[20:16] == a_q[20:16]) mem[k] = 16'hFFFF;
            busy_left = ERASE_CYC;
            step = 0;
        end else if (b == 8'hF0) begin
            step = 0;
            ident = 1'b0;
        end else if (step == 2 && b == 8'h90) begin
            ident = 1'b1;
            step = 0;
        end else if (step == 2 && (b == 8'hA0 || b == 8'h80)) begin
            step = (b == 8'hA0) ? 3 : 4;
        end else if (((step == 0 || step == 4) && b == 8'hAA) || ((step == 1 || step == 5) && b == 8'h55)) begin
            step++;
        end else begin
            step = 0;
        end
    end
endmodule : fccs_card_model

// >>> dv/flash_card_command_sequencer_test.sv
`timescale 1ns/10ps
`include "fccs_consts.svh"

module flash_card_command_sequencer_test
    import fccs_pkg::*;
;
    localparam logic [15:0] ID_MFR = 16'h00C3; // arbitrary value
    localparam logic [15:0] ID_DEV = 16'h00D7; // arbitrary value
    logic        clk, srst, valid, ready, rsp_v, rsp_e, r_e, rst_n, lo_n, hi_n, oe_n, we_n, busy_n;
    fccs_op_e    op;
    logic [20:0] addr, card_a;
    logic [15:0] wdat, rsp_d, r_d, dout, q, bus;
    logic [1:0]  lanes, doe;
    logic [15:0] ref_mem [int];
    int          compares = 0;
    int          miscompares = 0;
    int          cycles = 0;

    fccs_ctrl fccs_ctrl_i (.i_clk_sys(clk), .i_srst(srst), .i_cmd_valid(valid), .i_cmd_op(op),
        .i_cmd_addr(addr), .i_cmd_data(wdat), .i_cmd_lanes(lanes), .o_cmd_ready(ready),
        .o_rsp_valid(rsp_v), .o_rsp_err(rsp_e), .o_rsp_data(rsp_d), .o_window_open(),
        .o_card_busy(), .o_reset_n(rst_n), .o_low_lane_select_n(lo_n),
        .o_high_lane_select_n(hi_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(card_a),
        .o_data(dout), .o_data_oe(doe), .i_data(bus), .i_busy_n(busy_n));
    fccs_card_model #(.MFR_CODE(ID_MFR), .DEV_CODE(ID_DEV)) fccs_card_model_i (.i_reset_n(rst_n),
        .i_lo_n(lo_n), .i_hi_n(hi_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(card_a),
        .i_bus(bus), .o_q(q), .o_busy_n(busy_n));

    assign bus = {doe[1] ? dout[15:8] : q[15:8], doe[0] ? dout[7:0] : q[7:0]};

    function automatic logic [15:0] ref_rd(input logic [20:0] a);
        return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 16'hFFFF;
    endfunction : ref_rd

    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cmd(input fccs_op_e o, input logic [20:0] a,
                       input logic [15:0] d = 16'h0000, input logic [1:0] ln = 2'h3);
        @(posedge clk);
        valid <= 1'b1;
        op <= o;
        addr <= a;
        wdat <= d;
        lanes <= ln;
        do @(posedge clk); while (ready !== 1'b1);
        valid <= 1'b0;
        do @(posedge clk); while (rsp_v !== 1'b1);
        r_d = rsp_d;
        r_e = rsp_e;
        if (o == FCCS_OP_PROGRAM) ref_mem[int'(a)] = ref_rd(a) & d;
    endtask : cmd

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        logic [20:0] a;
        logic [15:0] d, m;
        srst = 1'b1;
        valid = 1'b0;
        op = FCCS_OP_READ;
        addr = 21'h0;
        wdat = 16'h0;
        lanes = 2'h3;
        d = 16'($urandom(32'hC29EBA2A));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        cmd(FCCS_OP_READ, 21'h000100);
        check("erased read", 16'hFFFF, r_d);
        for (int i = 0; i < 4; i++) begin
            a = 21'($urandom) & 21'h02FFFF;
            d = 16'($urandom);
            cmd(FCCS_OP_PROGRAM, a, d);
            cmd(FCCS_OP_PROGRAM, a, ~d | 16'($urandom));
            cmd(FCCS_OP_READ, a);
            check("program", ref_rd(a), r_d);
        end
        for (int ln = 1; ln < 3; ln++) begin
            m = (ln == 1) ? 16'h00FF : 16'hFF00;
            cmd(FCCS_OP_READ, a, 16'h0000, 2'(ln));
            check("lane read", ref_rd(a) & m, r_d & m);
        end
        cmd(FCCS_OP_IDENT, 21'h0);
        cmd(FCCS_OP_READ, 21'h0);
        check("maker code", ID_MFR, r_d);
        cmd(FCCS_OP_READ, 21'h1);
        check("device code", ID_DEV, r_d);
        cmd(FCCS_OP_RESET, 21'h0);
        cmd(FCCS_OP_READ, a);
        check("ident left", ref_rd(a), r_d);
        cmd(FCCS_OP_IDENT, 21'h0);
        cmd(FCCS_OP_HW_RESET, 21'h0);
        cmd(FCCS_OP_READ, 21'h1);
        check("after card reset", ref_rd(21'h1), r_d);
        cmd(FCCS_OP_PROGRAM, 21'h030010, 16'h1234);
        cmd(FCCS_OP_PROGRAM, 21'h040010, 16'h5678);
        cmd(FCCS_OP_SECT_ER, 21'h030000);
        cmd(FCCS_OP_ADD_SECT, 21'h050000);
        check("add in window", 16'h0000, {15'h0, r_e});
        cmd(FCCS_OP_WAIT, 21'h030000);
        foreach (ref_mem[k]) if (k[20:16] == 5'h03) ref_mem[k] = 16'hFFFF;
        cmd(FCCS_OP_READ, 21'h030010);
        check("erased sector", ref_rd(21'h030010), r_d);
        cmd(FCCS_OP_READ, 21'h040010);
        check("kept sector", ref_rd(21'h040010), r_d);
        cmd(FCCS_OP_PROGRAM, 21'h030010, 16'h00FF);
        cmd(FCCS_OP_ADD_SECT, 21'h060000);
        check("add after window", 16'h0001, {15'h0, r_e});
        cmd(FCCS_OP_CHIP_ER, 21'h0);
        ref_mem.delete();
        cmd(FCCS_OP_SUSPEND, 21'h0);
        cmd(FCCS_OP_RESUME, 21'h0);
        cmd(FCCS_OP_READ, 21'h040010);
        check("chip erased", ref_rd(21'h040010), r_d);
        complete_run();
    end
endmodule : flash_card_command_sequencer_test

bind fccs_ctrl fccs_ctrl_monitor fccs_ctrl_monitor_i (.*);
